// file: hw/mit_timers.sv
// internal timers: bus watchdog, adc settle, tracking, pin io timing
`default_nettype none
module mit_timers
  import mit_pkg::*;
#(
  parameter int WDOG_LEN   = mit_pkg::WDOG_US,
  parameter int SETTLE_LEN = mit_pkg::ADC_SETTLE_US,
  parameter int ARM_LEN    = mit_pkg::ARM_US,
  parameter int HOLD_LEN   = mit_pkg::HOLD_US,
  parameter int SETUP_LEN  = mit_pkg::SETUP_US,
  parameter int DEC_LEN    = mit_pkg::DEC_US
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  input  wire logic [1:0]               gpio_in,
  input  wire mit_pkg::mit_io_cmd_t     io_cmd,
  input  wire logic                     adc_mux_change,
  input  wire logic                     track_arm,
  input  wire logic                     track_cmd,
  input  wire logic                     track_on_start,
  input  wire logic                     track_off_start,
  input  wire logic [mit_pkg::OFS_W-1:0] track_ofs_init,
  output logic                          bus_abort,
  output logic                          txn_active,
  output logic [1:0]                    gpio_rd_data,
  output logic [1:0]                    gpio_oe,
  output logic                          adc_conv_start,
  output logic                          arm_pending,
  output logic                          arm_abort,
  output logic                          tracking_handshake_pin_oe,
  output logic                          current_output_dac_disconnect,
  output logic [mit_pkg::OFS_W-1:0]     track_ofs,
  output logic                          track_done
);
  import mit_pkg::*;

  // two-flop synchronisers, plus a third stage for edge detect
  logic [3:0] s1_reg, s2_reg, s3_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= 4'hf;
      s2_reg <= 4'hf;
      s3_reg <= 4'hf;
    end else begin
      s1_reg <= {gpio_in, sda_in, scl_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  logic scl_rise, start_cond, stop_cond;
  assign scl_rise   = s2_reg[0] & ~s3_reg[0];
  assign start_cond = s2_reg[0] & s3_reg[0] & ~s2_reg[1] & s3_reg[1];
  assign stop_cond  = s2_reg[0] & s3_reg[0] & s2_reg[1] & ~s3_reg[1];

  // common microsecond time base for every timer
  logic [4:0] pre_reg, pre_next;
  logic       tick;
  assign tick = (pre_reg == 5'(TICK_CYC - 1));
  always_comb begin
    pre_next = tick ? 5'h0 : pre_reg + 5'h1;
  end
  always_ff @(posedge clk) begin
    if (rst) pre_reg <= '0;
    else     pre_reg <= pre_next;
  end

  // watchdog runs from start to stop of each transaction
  logic wd_exp;
  logic wd_start;
  mit_timer #(.W(TMR_W)) u_wdog (
    .clk     (clk),
    .rst     (rst),
    .start   (wd_start),
    .stop    (stop_cond),
    .tick    (tick),
    .len     (TMR_W'(WDOG_LEN)),
    .busy    (),
    .expired (wd_exp)
  );

  // transaction tracking and scl edge count
  logic [EDGE_W-1:0] edge_reg, edge_next;
  logic              txn_reg, txn_next;
  logic [1:0]        rd_reg, rd_next, oe_reg, oe_next;
  always_comb begin
    edge_next = edge_reg;
    txn_next  = txn_reg;
    rd_next   = rd_reg;
    oe_next   = oe_reg;
    if (wd_exp || stop_cond) begin
      txn_next  = 1'b0; // abandon the command on timeout
      edge_next = '0;
    end else if (start_cond && !txn_reg) begin
      txn_next  = 1'b1;
      edge_next = '0;
    end else if (scl_rise && txn_reg && edge_reg != '1) begin
      edge_next = edge_reg + EDGE_W'(1);
      // pins sampled right at the 26th rise
      if (edge_next == RD_EDGE && io_cmd.read_cmd)
        rd_next = s2_reg[3:2];
      // applied a cycle later, far inside OUT_MAX_CYC
      if (edge_next == WR_EDGE && io_cmd.write_cmd)
        oe_next = io_cmd.wr_low;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      edge_reg <= '0;
      txn_reg  <= 1'b0;
      rd_reg   <= 2'h0;
      oe_reg   <= 2'h0;
    end else begin
      edge_reg <= edge_next;
      txn_reg  <= txn_next;
      rd_reg   <= rd_next;
      oe_reg   <= oe_next;
    end
  end
  // a repeated start must not stretch a stalled command
  assign wd_start     = start_cond & ~txn_reg;
  assign bus_abort    = wd_exp;
  assign txn_active   = txn_reg;
  assign gpio_rd_data = rd_reg;
  assign gpio_oe      = oe_reg;

  // adc settle after each mux change; a new change restarts it
  mit_timer #(.W(TMR_W)) u_settle (
    .clk     (clk),
    .rst     (rst),
    .start   (adc_mux_change),
    .stop    (1'b0),
    .tick    (tick),
    .len     (TMR_W'(SETTLE_LEN)),
    .busy    (),
    .expired (adc_conv_start)
  );

  // pending arm dropped if no tracking command in time
  mit_timer #(.W(TMR_W)) u_arm (
    .clk     (clk),
    .rst     (rst),
    .start   (track_arm),
    .stop    (track_cmd),
    .tick    (tick),
    .len     (TMR_W'(ARM_LEN)),
    .busy    (arm_pending),
    .expired (arm_abort)
  );

  // tracking sequencer: hold, setup and decrement phases
  mit_trk_state_t     st_reg, st_next;
  logic [OFS_W-1:0]   ofs_reg, ofs_next;
  logic               hs_reg, hs_next;
  logic               disc_reg, disc_next;
  logic               done_reg, done_next;
  logic               tr_start, tr_exp;
  logic [TMR_W-1:0]   tr_len;
  always_comb begin
    st_next   = st_reg;
    ofs_next  = ofs_reg;
    hs_next   = hs_reg;
    disc_next = 1'b0;
    done_next = 1'b0;
    tr_start  = 1'b0;
    tr_len    = TMR_W'(HOLD_LEN);
    case (st_reg)
      TRK_IDLE: begin
        if (track_on_start) begin
          hs_next  = 1'b1; // pin driven low
          tr_start = 1'b1;
          tr_len   = TMR_W'(HOLD_LEN);
          st_next  = TRK_ON_HOLD;
        end else if (track_off_start) begin
          hs_next  = 1'b0; // pin released high
          ofs_next = track_ofs_init;
          tr_start = 1'b1;
          tr_len   = TMR_W'(SETUP_LEN);
          st_next  = TRK_OFF_SETUP;
        end
      end
      TRK_ON_HOLD: begin
        if (tr_exp) begin
          disc_next = 1'b1;
          st_next   = TRK_IDLE;
        end
      end
      TRK_OFF_SETUP: begin
        if (tr_exp) begin
          tr_start = 1'b1;
          tr_len   = TMR_W'(DEC_LEN);
          st_next  = TRK_DEC;
        end
      end
      TRK_DEC: begin
        if (ofs_reg == '0) begin
          done_next = 1'b1;
          st_next   = TRK_IDLE;
        end else if (tr_exp) begin
          ofs_next = ofs_reg - OFS_W'(1);
          tr_start = 1'b1;
          tr_len   = TMR_W'(DEC_LEN);
        end
      end
      default: st_next = TRK_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg   <= TRK_IDLE;
      ofs_reg  <= '0;
      hs_reg   <= 1'b0;
      disc_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      ofs_reg  <= ofs_next;
      hs_reg   <= hs_next;
      disc_reg <= disc_next;
      done_reg <= done_next;
    end
  end

  mit_timer #(.W(TMR_W)) u_track (
    .clk     (clk),
    .rst     (rst),
    .start   (tr_start),
    .stop    (1'b0),
    .tick    (tick),
    .len     (tr_len),
    .busy    (),
    .expired (tr_exp)
  );

  assign tracking_handshake_pin_oe     = hs_reg;
  assign current_output_dac_disconnect = disc_reg;
  assign track_ofs                     = ofs_reg;
  assign track_done                    = done_reg;
endmodule
`default_nettype wire

// file: hw/mit_pkg.sv
// constants and carrier types for the supply monitor internal timers
`default_nettype none
package mit_pkg;
  localparam int CLK_NS       = 40;
  localparam int TICK_NS      = 1000;
  localparam int TICK_CYC     = TICK_NS / CLK_NS;
  localparam int TMR_W        = 18;
  localparam int WDOG_US      = 32000;
  localparam int ADC_SETTLE_US = 304;
  localparam int ARM_US       = 255000;
  localparam int HOLD_US      = 32000;
  localparam int SETUP_US     = 32000;
  localparam int DEC_US       = 88;
  localparam int OUT_MAX_NS   = 2500;
  // longest allowed lag of pin update, rounded down
  localparam int OUT_MAX_CYC  = OUT_MAX_NS / CLK_NS;
  localparam int EDGE_W       = 6;
  localparam logic [5:0] RD_EDGE = 6'h1a;
  localparam logic [5:0] WR_EDGE = 6'h23;
  localparam int OFS_W        = 10;

  typedef struct packed {
    logic       read_cmd;
    logic       write_cmd;
    logic [1:0] wr_low;
  } mit_io_cmd_t;

  typedef enum logic [1:0] {
    TRK_IDLE,
    TRK_ON_HOLD,
    TRK_OFF_SETUP,
    TRK_DEC
  } mit_trk_state_t;
endpackage
`default_nettype wire

// file: hw/mit_timer.sv
// one-shot timer counting time-base ticks
`default_nettype none
module mit_timer #(
  parameter int W = 18
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic         tick,
  input  wire logic [W-1:0] len,
  output logic              busy,
  output logic              expired
);
  logic [W-1:0] cnt_reg, cnt_next;
  logic         busy_reg, busy_next;
  logic         exp_reg, exp_next;

  // start wins over stop so a restart is never lost
  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    exp_next  = 1'b0;
    if (start) begin
      cnt_next  = len;
      busy_next = 1'b1;
    end else if (stop) begin
      busy_next = 1'b0;
    end else if (busy_reg && tick) begin
      if (cnt_reg <= W'(1)) begin
        busy_next = 1'b0;
        exp_next  = 1'b1;
      end else begin
        cnt_next = cnt_reg - W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      exp_reg  <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
      exp_reg  <= exp_next;
    end
  end

  assign busy    = busy_reg;
  assign expired = exp_reg;
endmodule
`default_nettype wire

// file: tb/mit_props.sv
// checker: timing relations seen at the timer block ports
`default_nettype none
module mit_props #(
  parameter int WD = 20,
  parameter int ST = 5,
  parameter int AR = 30,
  parameter int HD = 10
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       bus_abort,
  input wire logic       txn_active,
  input wire logic       adc_mux_change,
  input wire logic       adc_conv_start,
  input wire logic       track_arm,
  input wire logic       arm_pending,
  input wire logic       arm_abort,
  input wire logic       tracking_handshake_pin_oe,
  input wire logic       current_output_dac_disconnect,
  input wire logic [9:0] track_ofs
);
  timeunit 1ns;
  timeprecision 1ns;
  // windows allow one tick of slack either way
  localparam int S1 = ST * 25 - 33;
  localparam int S2 = ST * 25 + 19;
  localparam int H1 = HD * 25 - 26;
  localparam int H2 = HD * 25 + 27;
  int wc;
  int ac;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // cycles spent in a transaction and since the last arm
  always_ff @(posedge clk) begin
    wc <= txn_active ? wc + 1 : 0;
    ac <= (rst || track_arm) ? 0 : ac + 1;
  end
  // no start in the first 8 cycles, then one start inside the settle window
  sequence settled_s;
    !adc_conv_start [*8] ##[S1:S2] adc_conv_start;
  endsequence
  abort_pulse_a: assert property (bus_abort |=> !bus_abort)
    else $error("abort longer than one cycle");
  // the transaction flag drops on the edge after the abort pulse
  abort_end_a: assert property (
    bus_abort |-> txn_active ##1 !txn_active)
    else $error("abort without ending the transaction");
  wdog_len_a: assert property (
    bus_abort |-> wc >= WD * 25 - 28 && wc <= WD * 25 + 25)
    else $error("watchdog length wrong");
  adc_settle_a: assert property (adc_mux_change |=> settled_s)
    else $error("conversion start outside settle window");
  arm_set_a: assert property (track_arm |=> arm_pending)
    else $error("arm not pending");
  arm_end_a: assert property (
    arm_abort |-> $past(arm_pending) && !arm_pending
      && ac >= AR * 25 - 26 && ac <= AR * 25 + 27)
    else $error("arm abort timing wrong");
  hold_delay_a: assert property (
    $rose(tracking_handshake_pin_oe) |->
      ##[H1:H2] current_output_dac_disconnect)
    else $error("disconnect delay wrong");
  ofs_step_a: assert property (
    $changed(track_ofs) && $past(track_ofs) != 10'h000
      |-> track_ofs == $past(track_ofs) - 10'h001)
    else $error("offset step not minus one");
endmodule
// attach to every timer block
bind mit_timers mit_props #(
  .WD(WDOG_LEN), .ST(SETTLE_LEN), .AR(ARM_LEN), .HD(HOLD_LEN)
) props_u (
  .clk, .rst, .bus_abort, .txn_active, .adc_mux_change,
  .adc_conv_start, .track_arm, .arm_pending, .arm_abort,
  .tracking_handshake_pin_oe, .current_output_dac_disconnect,
  .track_ofs
);
`default_nettype wire

// file: tb/mit_host.sv
// bus host model: frames on scl and sda, lines idle high
`default_nettype none
module mit_host (
  output var logic scl,
  output var logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-ups hold both lines high; scl stands still outside frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // start, n+1 scl rises at 320 ns, optional stop; rise k at 160+320k
  task automatic frame(input int n, input bit fin);
    sda = 1'b1;
    #160 sda = 1'b0;
    repeat (n) begin
      #160 scl = 1'b0;
      #80 sda = ~sda;
      #80 scl = 1'b1;
    end
    #160 scl = 1'b0;
    #80 sda = 1'b0;
    #80 scl = 1'b1;
    // without a stop the data line stays low: a stuck bus
    #160 sda = fin ? 1'b1 : 1'b0;
    #160;
  endtask
endmodule
`default_nettype wire

// file: tb/mit_timers_tb_top.sv
// self-checking bench for the timer block
`default_nettype none
module mit_timers_tb_top;
  import mit_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WD = 20, ST = 5, AR = 30, HD = 10, SU = 10, DC = 3;
  logic clk = 1'b0, rst = 1'b1, scl, sda, ab, ta, cs, ap, aa, oe, dd, td;
  logic [1:0] gpi = 2'h3, rd, go;
  logic [4:0] p = 5'h00;
  logic [9:0] ini = 10'h000, ofs, last;
  mit_io_cmd_t cmd = '0;
  int failures = 0, n_tests = 0, cyc = 0, nab = 0, n, v, w;
  int q[$];
  wire logic [4:0] o = {td, dd, aa, cs, ab};
  mit_host h_u (.scl(scl), .sda(sda));
  mit_timers #(.WDOG_LEN(WD), .SETTLE_LEN(ST), .ARM_LEN(AR),
    .HOLD_LEN(HD), .SETUP_LEN(SU), .DEC_LEN(DC)) dut_u (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .gpio_in(gpi),
    .io_cmd(cmd), .adc_mux_change(p[0]), .track_arm(p[1]),
    .track_cmd(p[2]), .track_on_start(p[3]), .track_off_start(p[4]),
    .track_ofs_init(ini), .bus_abort(ab), .txn_active(ta),
    .gpio_rd_data(rd), .gpio_oe(go), .adc_conv_start(cs),
    .arm_pending(ap), .arm_abort(aa), .tracking_handshake_pin_oe(oe),
    .current_output_dac_disconnect(dd), .track_ofs(ofs),
    .track_done(td));
  always #20 clk = ~clk;
  // hang guard and abort pulse count
  always @(posedge clk) begin
    cyc++;
    if (ab === 1'b1) nab++;
    if (cyc == 20000) begin
      failures++;
      test_done;
    end
  end
  task automatic test_done;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_n(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      failures++;
      $display("BAD %0t count %0d", $time, got);
    end
  endtask
  task automatic chk_v(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t value %0h", $time, got);
    end
  endtask
  // inputs move 2 ns after the rising edge
  task automatic tk(input int c);
    repeat (c) @(posedge clk);
    #2;
  endtask
  task automatic pulse(input int k);
    tk(1);
    p = 5'h01 << k;
    tk(1);
    p = 5'h00;
  endtask
  task automatic wt(input int k, input int lim, output int c);
    c = 0;
    while (o[k] !== 1'b1 && c < lim) begin
      tk(1);
      c++;
    end
  endtask
  initial begin
    void'($urandom(32'h0ea6));
    tk(3);
    rst = 1'b0;
    tk(3);
    // stuck bus: frame without stop
    fork h_u.frame(2, 1'b0); join_none
    wt(0, 9000, n);
    chk_n(n, WD * 25 - 60, WD * 25 + 27);
    // transaction flag falls one cycle after the abort pulse
    tk(1);
    chk_v(10'(ta), 10'h000);
    $display("end watchdog");
    // pin read at rise 26, then pin write at rise 35
    for (int i = 0; i < 2; i++) begin
      v = $urandom % 4;
      w = $urandom % 3 + 1;
      gpi = ~v[1:0];
      cmd.read_cmd = (i == 0);
      cmd.write_cmd = (i == 1);
      cmd.wr_low = w[1:0];
      fork h_u.frame(36, 1'b1); join_none
      // pins hold the read value only 2.5 us either side of rise 26
      #5960 gpi = v[1:0];
      #5040 gpi = ~v[1:0];
      #260 chk_v(10'(go), 10'h000);
      #2600 chk_v(10'(go), 10'(i ? w : 0));
      tk(1);
      if (i == 0) chk_v(10'(rd), 10'(v));
    end
    $display("end pins");
    pulse(0);
    wt(1, 9000, n);
    chk_n(n, ST * 25 - 30, ST * 25 + 27);
    $display("end settle");
    pulse(1);
    chk_v(10'(ap), 10'h001);
    wt(2, 9000, n);
    chk_n(n, AR * 25 - 30, AR * 25 + 27);
    pulse(1);
    tk(100);
    pulse(2);
    chk_v(10'(ap), 10'h000);
    wt(2, AR * 25 + 50, n);
    chk_n(n, AR * 25 + 50, AR * 25 + 50);
    $display("end arm");
    pulse(3);
    chk_v(10'(oe), 10'h001);
    wt(3, 9000, n);
    chk_n(n, HD * 25 - 30, HD * 25 + 27);
    $display("end track on");
    ini = 10'($urandom % 4 + 1);
    for (int k = ini - 1; k >= 0; k--) q.push_back(k);
    pulse(4);
    chk_v(10'(oe), 10'h000);
    chk_v(ofs, ini);
    last = ini;
    for (int k = 0; q.size() > 0; k++) begin
      n = 0;
      while (ofs === last && n < 2000) begin
        tk(1);
        n++;
      end
      if (k == 0) chk_n(n, SU * 25 - 30, (SU + DC) * 25 + 27);
      else chk_n(n, DC * 25 - 30, DC * 25 + 27);
      last = ofs;
      chk_v(ofs, 10'(q.pop_front()));
    end
    wt(4, 10, n);
    chk_n(n, 0, 3);
    chk_n(nab, 1, 1);
    $display("end track off");
    test_done;
  end
endmodule
`default_nettype wire
